/* File: hdl/csms_pkg.sv */
package csms_pkg;
   // Register byte addresses
   localparam logic [7:0] CSMS_CSC_OFS = 8'h00;
   localparam logic [7:0] CSMS_ODC_OFS = 8'h04;
   localparam logic [7:0] CSMS_STAT_OFS = 8'h08;
   localparam logic [7:0] CSMS_ADJ_OFS = 8'h0C;
   // clock_source_control fields
   localparam int CSMS_SRC_HI = 7;
   localparam int CSMS_SRC_LO = 6;
   localparam int CSMS_REFERENCE_DIVIDER_HI = 5;
   localparam int CSMS_REFERENCE_DIVIDER_LO = 3;
   localparam int CSMS_IREF_SEL = 2;
   localparam int CSMS_IREF_OE = 1;
   localparam int CSMS_IREF_STEN = 0;
   // oscillator_divider_control fields
   localparam int CSMS_BUS_DIVIDER_HI = 7;
   localparam int CSMS_BUS_DIVIDER_LO = 6;
   localparam int CSMS_RANGE = 5;
   localparam int CSMS_GAIN = 4;
   localparam int CSMS_FLL_OFF = 3;
   localparam int CSMS_EREF_KIND = 2;
   localparam int CSMS_EREF_OE = 1;
   localparam int CSMS_EREF_STEN = 0;
   // Adjust register: trim in 7:0, fine bit in 8
   localparam int CSMS_FINE_BIT = 8;
   localparam logic [8:0] CSMS_ADJ_RST = 9'h080;
   // Reset values: internal FLL-engaged mode, bus divide by 4
   localparam logic [7:0] CSMS_CSC_RST = 8'h04;
   localparam logic [7:0] CSMS_ODC_RST = 8'h40;
   // Source-select field codes
   localparam logic [1:0] CSMS_SEL_FLL = 2'b00;
   localparam logic [1:0] CSMS_SEL_INT = 2'b01;
   localparam logic [1:0] CSMS_SEL_EXT = 2'b10;
   // Bus clock source currently driving the output, Gray along FLL-INT-EXT
   typedef enum logic [1:0] {
      CSMS_SRC_FLL = 2'b00,
      CSMS_SRC_INT = 2'b01,
      CSMS_SRC_EXT = 2'b11
   } csms_src_t;
endpackage : csms_pkg

/* File: hdl/csms_clock_source.sv */
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module csms_clock_source
   import csms_pkg::*;
#(
   parameter int REF_DIV_W = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fll_clk_tick,
   input wire logic fll_ready,
   input wire logic int_ref_tick,
   input wire logic int_ref_ready,
   input wire logic ext_ref_tick,
   input wire logic oscillator_ready_flag,
   input wire logic stop_mode,
   input wire logic background_debug_mode,
   output logic bus_clk,
   output logic fll_ref_tick,
   output logic fll_enable,
   output logic internal_ref_clock_out,
   output logic external_ref_clock_out,
   output logic int_ref_run,
   output logic ext_ref_run,
   output logic osc_high_range,
   output logic osc_high_gain,
   output logic osc_crystal_req,
   output logic [8:0] adjust_out
);

   if (REF_DIV_W < 7) begin : g_ref_div_chk
      $error("REF_DIV_W must reach divide by 128");
   end

   function automatic logic [2:0] bus_divider_term(input logic [1:0] code);
      bus_divider_term = 3'((4'h1 << code) - 4'h1);
   endfunction : bus_divider_term

   function automatic logic [REF_DIV_W-1:0] reference_divider_term(input logic [2:0] code);
      reference_divider_term = REF_DIV_W'((8'h01 << code) - 8'h01);
   endfunction : reference_divider_term

   logic [7:0] csc_q;
   logic [7:0] odc_q;
   logic [8:0] adj_q;
   csms_src_t cur_q;
   csms_src_t want_w;
   logic want_ok_w;
   logic [2:0] div_cnt_q;
   logic bus_clk_q;
   logic [REF_DIV_W-1:0] ref_cnt_q;
   logic fll_ref_q;
   logic fll_en_q;
   logic iref_out_q;
   logic eref_out_q;
   logic iref_run_q;
   logic eref_run_q;
   logic [31:0] prdata_q;

   // Field views
   wire logic [1:0] src_field = csc_q[CSMS_SRC_HI:CSMS_SRC_LO];
   wire logic [2:0] reference_divider = csc_q[CSMS_REFERENCE_DIVIDER_HI:CSMS_REFERENCE_DIVIDER_LO];
   wire logic iref_sel = csc_q[CSMS_IREF_SEL];
   wire logic [1:0] bus_divider = odc_q[CSMS_BUS_DIVIDER_HI:CSMS_BUS_DIVIDER_LO];
   wire logic lp_bit = odc_q[CSMS_FLL_OFF];

   // APB decode
   wire logic setup_w = psel & ~penable;
   wire logic wr_w = psel & penable & pwrite & pstrb[0];
   wire logic hit_csc = (paddr == CSMS_CSC_OFS);
   wire logic hit_odc = (paddr == CSMS_ODC_OFS);
   wire logic hit_stat = (paddr == CSMS_STAT_OFS);
   wire logic hit_adj = (paddr == CSMS_ADJ_OFS);
   wire logic hit_any = hit_csc | hit_odc | hit_stat | hit_adj;
   wire logic ro_wr = pwrite & hit_stat;

   assign pready = 1'b1;
   assign pslverr = psel & penable & (~hit_any | ro_wr);
   assign prdata = prdata_q;

   // Requested source; code 11 is reserved and keeps the present source
   always_comb begin
      if (src_field == CSMS_SEL_FLL) begin
         want_w = CSMS_SRC_FLL;
      end else if (src_field == CSMS_SEL_INT) begin
         want_w = CSMS_SRC_INT;
      end else if (src_field == CSMS_SEL_EXT) begin
         want_w = CSMS_SRC_EXT;
      end else begin
         want_w = cur_q;
      end
   end

   wire logic bypass_w = (want_w != CSMS_SRC_FLL) && (cur_q != CSMS_SRC_FLL);
   wire logic fll_on_w = ~(lp_bit & bypass_w & ~background_debug_mode);
   wire logic ref_tick_w = iref_sel ? int_ref_tick : ext_ref_tick;

   always_comb begin
      case (want_w)
         CSMS_SRC_INT: want_ok_w = int_ref_ready;
         CSMS_SRC_EXT: want_ok_w = oscillator_ready_flag;
         default: want_ok_w = fll_ready & fll_on_w;
      endcase
   end

   wire logic sel_tick_w = (cur_q == CSMS_SRC_INT) ? int_ref_tick :
                           (cur_q == CSMS_SRC_EXT) ? ext_ref_tick : fll_clk_tick;
   // Compare with >= so a divider shrunk mid-count ends on the next source tick instead of wrapping around
   wire logic div_end_w = sel_tick_w && (div_cnt_q >= bus_divider_term(bus_divider));
   // Switch only in the low phase at a divider boundary so no short high pulse appears
   wire logic switch_w = (want_w != cur_q) && want_ok_w && ~bus_clk_q && (div_cnt_q == 3'h0);
   wire logic ref_end_w = ref_tick_w && (ref_cnt_q >= reference_divider_term(reference_divider));

   wire logic [7:0] stat_w = {3'h0, fll_en_q, (want_w != cur_q), cur_q, oscillator_ready_flag};
   wire logic [7:0] rd_byte_w = hit_csc ? csc_q : hit_odc ? odc_q : hit_stat ? stat_w : 8'h00;
   wire logic [31:0] rd_word_w = hit_adj ? {23'h0, adj_q} : {24'h0, rd_byte_w};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csc_q <= CSMS_CSC_RST;
         odc_q <= CSMS_ODC_RST;
         prdata_q <= 32'h0000_0000;
      end else begin
         if (wr_w && hit_csc) begin
            csc_q <= pwdata[7:0];
         end
         if (wr_w && hit_odc) begin
            odc_q <= pwdata[7:0];
         end
         if (setup_w) begin
            prdata_q <= rd_word_w;
         end
      end
   end

   // Trim only clears on power-on, not on the functional reset
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         adj_q <= CSMS_ADJ_RST;
      end else if (wr_w && hit_adj) begin
         adj_q <= pwdata[8:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= CSMS_SRC_FLL;
         div_cnt_q <= 3'h0;
         bus_clk_q <= 1'b0;
      end else begin
         case (cur_q)
            CSMS_SRC_FLL, CSMS_SRC_INT, CSMS_SRC_EXT: begin
               if (switch_w) begin
                  cur_q <= want_w;
               end
            end
            default: cur_q <= CSMS_SRC_FLL;
         endcase
         if (switch_w) begin
            div_cnt_q <= 3'h0;
         end else if (div_end_w) begin
            div_cnt_q <= 3'h0;
            bus_clk_q <= ~bus_clk_q;
         end else if (sel_tick_w) begin
            div_cnt_q <= div_cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_q <= '0;
         fll_ref_q <= 1'b0;
         fll_en_q <= 1'b1;
         iref_out_q <= 1'b0;
         eref_out_q <= 1'b0;
         iref_run_q <= 1'b1;
         eref_run_q <= 1'b0;
      end else begin
         if (ref_end_w) begin
            ref_cnt_q <= '0;
         end else if (ref_tick_w) begin
            ref_cnt_q <= ref_cnt_q + REF_DIV_W'(1);
         end
         fll_ref_q <= ref_end_w;
         fll_en_q <= fll_on_w;
         iref_out_q <= csc_q[CSMS_IREF_OE] & int_ref_tick & iref_run_q;
         eref_out_q <= odc_q[CSMS_EREF_OE] & ext_ref_tick & eref_run_q;
         iref_run_q <= ~stop_mode | csc_q[CSMS_IREF_STEN];
         eref_run_q <= (odc_q[CSMS_EREF_OE] | (cur_q == CSMS_SRC_EXT) | (want_w == CSMS_SRC_EXT) | ~iref_sel)
                       & (~stop_mode | odc_q[CSMS_EREF_STEN]);
      end
   end

   assign bus_clk = bus_clk_q;
   assign fll_ref_tick = fll_ref_q;
   assign fll_enable = fll_en_q;
   assign internal_ref_clock_out = iref_out_q;
   assign external_ref_clock_out = eref_out_q;
   assign int_ref_run = iref_run_q;
   assign ext_ref_run = eref_run_q;
   assign osc_high_range = odc_q[CSMS_RANGE];
   assign osc_high_gain = odc_q[CSMS_GAIN];
   assign osc_crystal_req = odc_q[CSMS_EREF_KIND];
   assign adjust_out = adj_q;

   bus_clk_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && (bus_clk_q != $past(bus_clk_q))) |-> $past(div_end_w) && !$past(switch_w))
      else $error("bus clock toggled off a divider boundary");

   src_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && (cur_q != $past(cur_q))) |-> $past(want_ok_w) && (cur_q == $past(want_w)))
      else $error("source changed to an unavailable or unrequested clock");

   no_runt_a: assert property (@(posedge pclk) disable iff (!presetn)
      switch_w |=> !bus_clk_q && (div_cnt_q == 3'h0))
      else $error("switch did not restart the low phase");

   fll_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lp_bit && bypass_w && !background_debug_mode) |=> !fll_enable)
      else $error("FLL left running in low power bypass");

   iref_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      !csc_q[CSMS_IREF_OE] |=> !internal_ref_clock_out)
      else $error("internal reference output active while disabled");

   eref_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!odc_q[CSMS_EREF_OE] |=> !external_ref_clock_out) and
      ((stop_mode && !odc_q[CSMS_EREF_STEN]) |=> !ext_ref_run))
      else $error("external reference active while disabled");

   ref_div1_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && reference_divider == 3'h0 && ref_tick_w) |=> fll_ref_tick)
      else $error("reference divide by 1 missed a tick");

   reset_mode_a: assert property (@(posedge pclk)
      $rose(presetn) |-> (cur_q == CSMS_SRC_FLL) && (csc_q == CSMS_CSC_RST) && (odc_q == CSMS_ODC_RST))
      else $error("reset did not restore internal FLL mode");

   trim_keep_a: assert property (@(posedge pclk)
      (por_n && $past(por_n) && !$past(presetn)) |-> (adj_q == $past(adj_q)))
      else $error("trim changed during functional reset");

   // Sampled presetn in antecedents skips the release edge, at which the design is still held
   int_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && stop_mode && !csc_q[CSMS_IREF_STEN]) |=> !int_ref_run)
      else $error("internal reference left running in stop");

   src_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && (want_w != cur_q) && !want_ok_w) |=> (cur_q == $past(cur_q)))
      else $error("source left before the new clock was ready");

   fll_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && !lp_bit) |=> fll_enable)
      else $error("FLL off while its low power bit is clear");

   fll_debug_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && background_debug_mode) |=> fll_enable)
      else $error("FLL off while debug mode active");

   iref_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && csc_q[CSMS_IREF_OE] && int_ref_tick && int_ref_run) |=> internal_ref_clock_out)
      else $error("internal reference output missed a tick");

   eref_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && odc_q[CSMS_EREF_OE] && ext_ref_tick && ext_ref_run) |=> external_ref_clock_out)
      else $error("external reference output missed a tick");

endmodule : csms_clock_source

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import csms_pkg::*;
;
   logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0] pstrb = 4'hF;
   logic fll_clk_tick = 0, int_ref_tick = 0, ext_ref_tick = 0, oscillator_ready_flag = 1;
   logic stop_mode = 0, background_debug_mode = 0, fll_ready = 1, int_ref_ready = 1;
   logic pready, pslverr, e, bus_clk, fll_ref_tick, fll_enable, int_ref_run, ext_ref_run;
   logic internal_ref_clock_out, external_ref_clock_out, osc_high_range, osc_high_gain, osc_crystal_req;
   logic [8:0] adjust_out;
   logic [2:0] cyc = 3'h0;
   int bad_count = 0, num_checks = 0, n, i, j;
   logic [7:0] rtab [3] = '{8'h04, 8'h3C, 8'h00};
   int ptab [3] = '{4, 512, 8};

   csms_clock_source csms_clock_source_inst (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fll_clk_tick, .fll_ready, .int_ref_tick,
      .int_ref_ready, .ext_ref_tick, .oscillator_ready_flag, .stop_mode, .background_debug_mode,
      .bus_clk, .fll_ref_tick, .fll_enable, .internal_ref_clock_out, .external_ref_clock_out,
      .int_ref_run, .ext_ref_run, .osc_high_range, .osc_high_gain, .osc_crystal_req, .adjust_out);

   initial forever #2.5 pclk = ~pclk;

   // Source ticks at three rates so the period tells which source drives the bus clock
   always @(posedge pclk) begin
      cyc <= cyc + 3'h1;
      fll_clk_tick <= cyc[0];
      int_ref_tick <= &cyc[1:0];
      ext_ref_tick <= &cyc;
   end

   task automatic wrap_up();
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (k == 50) begin
         bad_count++;
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      xfer(1'b0, a, 32'h0);
      chk(nm, exp, q);
   endtask : rd

   // Cycles between two rising edges; 0 when fewer than two come within the bound
   task automatic meas(input int sel, output int m);
      logic p, s;
      int k, f;
      p = 1'b1;
      f = -1;
      m = 0;
      for (k = 0; k < 1100; k++) begin
         @(posedge pclk);
         s = sel == 0 ? bus_clk : sel == 1 ? fll_ref_tick : sel == 2 ? internal_ref_clock_out
            : external_ref_clock_out;
         if (s === 1'b1 && p !== 1'b1) begin
            if (f >= 0) begin
               m = k - f;
               return;
            end
            f = k;
         end
         p = s;
      end
   endtask : meas

   // First period after a switch may be irregular, so the second one is judged
   task automatic meas2(input int sel);
      meas(sel, n);
      meas(sel, n);
   endtask : meas2

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge pclk);
      rd(CSMS_CSC_OFS, 32'h04, "csc_reset");
      rd(CSMS_ODC_OFS, 32'h40, "odc_reset");
      rd(CSMS_ADJ_OFS, 32'h080, "adj_reset");
      meas2(0);
      chk("fll_period", 32'd8, n);
      xfer(1'b1, CSMS_ADJ_OFS, 32'h1AB);
      xfer(1'b1, CSMS_CSC_OFS, 32'h3C);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(CSMS_ADJ_OFS, 32'h1AB, "adj_kept");
      chk("adj_out", 32'h1AB, {23'h0, adjust_out});
      rd(CSMS_CSC_OFS, 32'h04, "csc_again");
      xfer(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      xfer(1'b1, CSMS_STAT_OFS, 32'hFF);
      chk("status_wr_err", 32'h1, {31'h0, e});
      for (i = 0; i < 2; i++) begin
         xfer(1'b1, CSMS_ODC_OFS, i ? 32'h00 : 32'h34);
         chk("osc_bits", i ? 32'h0 : 32'h7, {29'h0, osc_high_range, osc_high_gain, osc_crystal_req});
      end
      oscillator_ready_flag <= 1'b0;
      xfer(1'b1, CSMS_ODC_OFS, 32'h40);
      xfer(1'b1, CSMS_CSC_OFS, 32'hB8);
      meas2(0);
      chk("held_source", 32'd8, n);
      oscillator_ready_flag <= 1'b1;
      rd(CSMS_STAT_OFS, 32'h19, "osc_ready_poll");
      for (j = 0; j < 2; j++) begin
         for (i = 0; i < 2; i++) begin
            xfer(1'b1, CSMS_CSC_OFS, j ? 32'hB8 : 32'h44);
            xfer(1'b1, CSMS_ODC_OFS, {24'h0, i[1:0], 6'h00});
            meas2(0);
            chk("bus_period", 2 * (1 << i) * (j ? 8 : 4), n);
         end
      end
      rd(CSMS_STAT_OFS, 32'h17, "status_ext");
      xfer(1'b1, CSMS_ODC_OFS, 32'h48);
      @(posedge pclk);
      chk("fll_off", 32'h0, {31'h0, fll_enable});
      background_debug_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("fll_debug", 32'h1, {31'h0, fll_enable});
      background_debug_mode <= 1'b0;
      xfer(1'b1, CSMS_ODC_OFS, 32'h40);
      @(posedge pclk);
      chk("fll_on", 32'h1, {31'h0, fll_enable});
      for (i = 0; i < 3; i++) begin
         xfer(1'b1, CSMS_CSC_OFS, {24'h0, rtab[i]});
         meas2(1);
         chk("ref_period", ptab[i], n);
      end
      for (i = 0; i < 2; i++) begin
         xfer(1'b1, CSMS_CSC_OFS, i ? 32'h04 : 32'h06);
         xfer(1'b1, CSMS_ODC_OFS, i ? 32'h40 : 32'h42);
         meas(2, n);
         chk("int_out", i ? 0 : 4, n);
         meas(3, n);
         chk("ext_out", i ? 0 : 8, n);
      end
      stop_mode <= 1'b1;
      xfer(1'b1, CSMS_CSC_OFS, 32'h04);
      chk("int_stop", 32'h0, {31'h0, int_ref_run});
      chk("ext_stop", 32'h0, {31'h0, ext_ref_run});
      xfer(1'b1, CSMS_CSC_OFS, 32'h05);
      @(posedge pclk);
      chk("int_stop_en", 32'h1, {31'h0, int_ref_run});
      wrap_up();
   end
endmodule : tb_top
